// ===== design/ceau_map.vh
// Constants for the effective address unit: mode codes, lengths, limits.
// Assumes inclusion by bare name from the design file.
`ifndef CEAU_MAP_VH
`define CEAU_MAP_VH

// ----------------------------------------------------------------------
// Addressing modes
// ----------------------------------------------------------------------
`define CEAU_MODE_INH     4'h0
`define CEAU_MODE_IMM     4'h1
`define CEAU_MODE_DIR     4'h2
`define CEAU_MODE_EXT     4'h3
`define CEAU_MODE_IX0     4'h4
`define CEAU_MODE_IX1     4'h5
`define CEAU_MODE_IX2     4'h6
`define CEAU_MODE_REL     4'h7
`define CEAU_MODE_BSC     4'h8
`define CEAU_MODE_BTB     4'h9

// ----------------------------------------------------------------------
// Instruction classes
// ----------------------------------------------------------------------
`define CEAU_CLS_REGMEM   3'h0
`define CEAU_CLS_RMW      3'h1
`define CEAU_CLS_TST      3'h2
`define CEAU_CLS_JUMP     3'h3
`define CEAU_CLS_CALL     3'h4
`define CEAU_CLS_BRANCH   3'h5
`define CEAU_CLS_BIT      3'h6
`define CEAU_CLS_INH      3'h7

// ----------------------------------------------------------------------
// Program counter steps and page limits
// ----------------------------------------------------------------------
`define CEAU_STEP_1       16'h0001
`define CEAU_STEP_2       16'h0002
`define CEAU_STEP_3       16'h0003
`define CEAU_WRITABLE_TOP 8'h7F

// ----------------------------------------------------------------------
// Sequencer states
// ----------------------------------------------------------------------
`define CEAU_ST_IDLE      2'h0
`define CEAU_ST_ACCESS    2'h1
`define CEAU_ST_WRITE     2'h2

`endif

// ===== design/ceau_unit.v
// Effective address unit of an 8-bit CPU: forms the operand address,
// drives it on the address bus for the operand access and advances the PC.
// Assumes the fetch logic delivers opcode bytes, decoded mode and class,
// and the read operand, all synchronous to sys_clk.
`default_nettype none
`include "ceau_map.vh"

module ceau_unit (
  input  wire        sys_clk,
  input  wire        sys_rst,
  input  wire        instr_valid,
  input  wire [3:0]  addr_mode,
  input  wire [2:0]  instr_class,
  input  wire [7:0]  opcode,
  input  wire [7:0]  byte1,
  input  wire [7:0]  byte2,
  input  wire [15:0] pc_in,
  input  wire [7:0]  index_x,
  input  wire        branch_cond,
  input  wire        bit_sense,
  input  wire [7:0]  read_data,
  input  wire [7:0]  alu_result,
  output reg  [7:0]  addr_high,
  output reg  [7:0]  addr_low,
  output reg         mem_read,
  output reg         mem_write,
  output reg  [7:0]  write_data,
  output reg  [15:0] pc_out,
  output reg         pc_load,
  output reg         carry_load,
  output reg         carry_value,
  output reg         branch_taken,
  output reg         done
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function [15:0] ceau_sext;
    input [7:0] val;
    begin
      ceau_sext = {{8{val[7]}}, val};
    end
  endfunction

  function [7:0] ceau_bit_mask;
    input [2:0] num;
    begin
      ceau_bit_mask = 8'h01 << num;
    end
  endfunction

  function ceau_bit_of;
    input [7:0] data;
    input [2:0] num;
    begin
      ceau_bit_of = |(data & ceau_bit_mask(num));
    end
  endfunction

  // Jump and call only need the target, so they never spend a cycle on a read.
  function ceau_is_transfer;
    input [2:0] cls;
    begin
      ceau_is_transfer = (cls == `CEAU_CLS_JUMP) || (cls == `CEAU_CLS_CALL);
    end
  endfunction

  // ----------------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------------
  localparam [1:0] ST_IDLE   = `CEAU_ST_IDLE;
  localparam [1:0] ST_ACCESS = `CEAU_ST_ACCESS;
  localparam [1:0] ST_WRITE  = `CEAU_ST_WRITE;

  // ----------------------------------------------------------------------
  // Effective address and next PC
  // ----------------------------------------------------------------------
  reg  [15:0] ea_next;
  reg  [15:0] pc_next;
  reg         access_next;
  reg         taken_next;
  reg  [8:0]  low_sum;
  reg  [2:0]  bit_num;
  reg         tested_bit;

  always @* begin
    ea_next     = 16'h0000;
    pc_next     = pc_in + `CEAU_STEP_1;
    access_next = 1'b0;
    taken_next  = 1'b0;
    low_sum     = 9'h000;
    bit_num     = 3'h0;
    tested_bit  = 1'b0;
    case (addr_mode)
      `CEAU_MODE_INH: begin
        pc_next = pc_in + `CEAU_STEP_1;
      end
      `CEAU_MODE_IMM: begin
        ea_next     = pc_in + `CEAU_STEP_1;
        pc_next     = pc_in + `CEAU_STEP_2;
        access_next = 1'b1;
      end
      `CEAU_MODE_DIR: begin
        ea_next     = {8'h00, byte1};
        pc_next     = pc_in + `CEAU_STEP_2;
        access_next = 1'b1;
      end
      `CEAU_MODE_EXT: begin
        ea_next     = {byte1, byte2};
        pc_next     = pc_in + `CEAU_STEP_3;
        access_next = 1'b1;
      end
      `CEAU_MODE_IX0: begin
        ea_next     = {8'h00, index_x};
        pc_next     = pc_in + `CEAU_STEP_1;
        access_next = 1'b1;
      end
      `CEAU_MODE_IX1: begin
        low_sum     = {1'b0, index_x} + {1'b0, byte1};
        ea_next     = {7'h00, low_sum};
        pc_next     = pc_in + `CEAU_STEP_2;
        access_next = 1'b1;
      end
      `CEAU_MODE_IX2: begin
        low_sum     = {1'b0, index_x} + {1'b0, byte2};
        ea_next     = {byte1 + {7'h00, low_sum[8]}, low_sum[7:0]};
        pc_next     = pc_in + `CEAU_STEP_3;
        access_next = 1'b1;
      end
      `CEAU_MODE_REL: begin
        taken_next = branch_cond;
        pc_next    = branch_cond ? pc_in + `CEAU_STEP_2 + ceau_sext(byte1)
                                 : pc_in + `CEAU_STEP_2;
      end
      `CEAU_MODE_BSC: begin
        bit_num     = opcode[3:1];
        ea_next     = {8'h00, byte1};
        pc_next     = pc_in + `CEAU_STEP_2;
        access_next = 1'b1;
      end
      `CEAU_MODE_BTB: begin
        bit_num     = opcode[3:1];
        ea_next     = {8'h00, byte1};
        access_next = 1'b1;
        tested_bit  = ceau_bit_of(read_data, bit_num);
        taken_next  = (tested_bit == bit_sense);
        pc_next     = taken_next ? pc_in + `CEAU_STEP_3 + ceau_sext(byte2)
                                 : pc_in + `CEAU_STEP_3;
      end
      default: begin
        pc_next = pc_in + `CEAU_STEP_1;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Write-back decision
  // ----------------------------------------------------------------------
  reg        wb_next;
  reg  [7:0] wb_data_next;

  always @* begin
    wb_next      = 1'b0;
    wb_data_next = alu_result;
    if (addr_mode == `CEAU_MODE_BSC) begin
      wb_next      = (byte1 <= `CEAU_WRITABLE_TOP);
      wb_data_next = opcode[0] ? (read_data & ~ceau_bit_mask(opcode[3:1]))
                               : (read_data | ceau_bit_mask(opcode[3:1]));
    end else if (instr_class == `CEAU_CLS_RMW && addr_mode != `CEAU_MODE_INH) begin
      wb_next = 1'b1;
    end else begin
      wb_next = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Operand read decision
  // ----------------------------------------------------------------------
  // Immediate operands come with the fetched bytes, so no bus cycle is spent.
  reg        read_next;

  always @* begin
    read_next = access_next;
    if (addr_mode == `CEAU_MODE_IMM) begin
      read_next = 1'b0;
    end
    if (ceau_is_transfer(instr_class)) begin
      read_next = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Sequencer: operand read, optional write, then PC update
  // ----------------------------------------------------------------------
  reg  [1:0]  state_reg;
  reg  [15:0] ea_reg;
  reg  [15:0] pc_hold_reg;

  // A reset between the read and the write drops the write-back, so the
  // location keeps its old value rather than a half-finished update.
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg    <= ST_IDLE;
      ea_reg       <= 16'h0000;
      pc_hold_reg  <= 16'h0000;
      addr_high    <= 8'h00;
      addr_low     <= 8'h00;
      mem_read     <= 1'b0;
      mem_write    <= 1'b0;
      write_data   <= 8'h00;
      pc_out       <= 16'h0000;
      pc_load      <= 1'b0;
      carry_load   <= 1'b0;
      carry_value  <= 1'b0;
      branch_taken <= 1'b0;
      done         <= 1'b0;
    end else begin
      mem_read     <= 1'b0;
      mem_write    <= 1'b0;
      pc_load      <= 1'b0;
      carry_load   <= 1'b0;
      done         <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (instr_valid) begin
            ea_reg <= ea_next;
            if (read_next) begin
              addr_high <= ea_next[15:8];
              addr_low  <= ea_next[7:0];
              mem_read  <= 1'b1;
              state_reg <= ST_ACCESS;
            end else begin
              pc_out       <= ceau_is_transfer(instr_class) ? ea_next : pc_next;
              pc_load      <= 1'b1;
              branch_taken <= taken_next;
              done         <= 1'b1;
            end
          end
        end
        ST_ACCESS: begin
          // Read data is valid here, so the bit test resolves in this cycle.
          pc_out       <= pc_next;
          branch_taken <= taken_next;
          if (addr_mode == `CEAU_MODE_BTB) begin
            carry_load  <= 1'b1;
            carry_value <= ceau_bit_of(read_data, opcode[3:1]);
          end
          if (wb_next) begin
            addr_high  <= ea_reg[15:8];
            addr_low   <= ea_reg[7:0];
            write_data <= wb_data_next;
            mem_write  <= 1'b1;
            state_reg  <= ST_WRITE;
          end else begin
            pc_load   <= 1'b1;
            done      <= 1'b1;
            state_reg <= ST_IDLE;
          end
        end
        ST_WRITE: begin
          pc_load   <= 1'b1;
          done      <= 1'b1;
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ===== testbench/ceau_mem_model.sv
// Operand memory seen through the low address byte, for the address unit.
// Assumes reads and writes are pulses timed as the unit's hand-over states.
`default_nettype none

module ceau_mem_model (
  input  wire logic       sys_clk,
  input  wire logic [7:0] addr_low,
  input  wire logic       mem_read,
  input  wire logic       mem_write,
  input  wire logic [7:0] write_data,
  output logic      [7:0] read_data,
  output logic      [7:0] alu_result
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  logic       rd_d = 1'h0;
  initial for (int i = 0; i < 256; i++) mem[i] = i[7:0] ^ 8'h5A;
  always @(posedge sys_clk) begin
    rd_d <= mem_read;
    if (mem_write === 1'h1) mem[addr_low] <= write_data;
  end
  // Outside the read cycle and the cycle after it the data is inverted, so a sample later than that cannot pass.
  assign read_data  = (mem_read | rd_d) ? mem[addr_low] : ~mem[addr_low];
  assign alu_result = read_data + 8'h01;
endmodule

`default_nettype wire

// ===== testbench/ceau_unit_sva.sv
// Assertions on the ports of the effective address unit, bound to it.
// Assumes instruction inputs stay steady from acceptance until done.
`default_nettype none
`include "ceau_map.vh"

module ceau_unit_sva (
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic [3:0]  addr_mode,
  input wire logic [2:0]  instr_class,
  input wire logic [7:0]  byte1,
  input wire logic [7:0]  byte2,
  input wire logic [15:0] pc_in,
  input wire logic [7:0]  index_x,
  input wire logic [7:0]  addr_high,
  input wire logic [7:0]  addr_low,
  input wire logic        mem_read,
  input wire logic        mem_write,
  input wire logic [15:0] pc_out,
  input wire logic        pc_load,
  input wire logic        carry_load,
  input wire logic        done
);
  wire [15:0] ea = {addr_high, addr_low};
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence s_rmw_read;
    mem_read && instr_class == `CEAU_CLS_RMW && addr_mode == `CEAU_MODE_DIR;
  endsequence
  sequence s_write_back;
    mem_write && $stable(ea) ##1 done && pc_load;
  endsequence
  a_rmw_same_place: assert property (s_rmw_read |=> s_write_back)
    else $error("write back late or at another address");
  a_dir_address: assert property (mem_read && addr_mode == `CEAU_MODE_DIR |-> ea == {8'h00, byte1})
    else $error("direct address wrong");
  a_ext_address: assert property (mem_read && addr_mode == `CEAU_MODE_EXT |-> ea == {byte1, byte2})
    else $error("extended address wrong");
  a_ix0_address: assert property (mem_read && addr_mode == `CEAU_MODE_IX0 |-> ea == {8'h00, index_x})
    else $error("indexed address wrong");
  a_ix1_address: assert property (mem_read && addr_mode == `CEAU_MODE_IX1 |->
    ea == {8'h00, index_x} + {8'h00, byte1}) else $error("short offset address wrong");
  a_ix2_address: assert property (mem_read && addr_mode == `CEAU_MODE_IX2 |->
    ea == {byte1, 8'h00} + {8'h00, index_x} + {8'h00, byte2}) else $error("long offset wrong");
  a_imm_next_pc: assert property (pc_load && $past(addr_mode) == `CEAU_MODE_IMM |->
    pc_out == pc_in + 16'h0002)
    else $error("immediate next pc wrong");
  a_test_no_write: assert property (instr_class == `CEAU_CLS_TST |-> !mem_write)
    else $error("test instruction wrote back");
  a_bit_low_page: assert property (mem_write && addr_mode == `CEAU_MODE_BSC |->
    addr_high == 8'h00 && addr_low <= 8'h7F) else $error("bit write outside writable page");
  a_carry_at_end: assert property (carry_load |-> done && $past(addr_mode) == `CEAU_MODE_BTB)
    else $error("carry loaded outside bit test");
endmodule

bind ceau_unit ceau_unit_sva chk (.*);

`default_nettype wire

// ===== testbench/ceau_unit_tb.sv
// Self-checking bench for the effective address unit with a memory partner.
// Assumes the unit accepts one instruction at a time as its hand-over states.
`default_nettype none

module ceau_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // Flags f: branch condition, bit sense, read, write, carry.
  typedef struct packed {
    logic [3:0] m; logic [2:0] c; logic [7:0] op, b1, b2, x;
    logic [4:0] f; logic [15:0] pc, ea; logic [7:0] wd;
  } ceau_row_t;
  localparam ceau_row_t ROWS [17] = '{
    '{4'h1, 3'h0, 8'hA6, 8'h11, 8'h00, 8'h00, 5'h00, 16'h10F2, 16'h0000, 8'h00},
    '{4'h2, 3'h1, 8'h3C, 8'h40, 8'h00, 8'h00, 5'h06, 16'h10F2, 16'h0040, 8'h1B},
    '{4'h3, 3'h0, 8'hC6, 8'hAB, 8'hCD, 8'h00, 5'h04, 16'h10F3, 16'hABCD, 8'h00},
    '{4'h4, 3'h0, 8'hF6, 8'h00, 8'h00, 8'hFF, 5'h04, 16'h10F1, 16'h00FF, 8'h00},
    '{4'h5, 3'h0, 8'hE6, 8'hFF, 8'h00, 8'hFF, 5'h04, 16'h10F2, 16'h01FE, 8'h00},
    '{4'h6, 3'h0, 8'hD6, 8'h12, 8'h90, 8'h80, 5'h04, 16'h10F3, 16'h1310, 8'h00},
    '{4'h7, 3'h5, 8'h20, 8'h80, 8'h00, 8'h00, 5'h10, 16'h1072, 16'h0000, 8'h00},
    '{4'h7, 3'h5, 8'h20, 8'h7F, 8'h00, 8'h00, 5'h00, 16'h10F2, 16'h0000, 8'h00},
    '{4'h3, 3'h3, 8'hCC, 8'h20, 8'h00, 8'h00, 5'h00, 16'h2000, 16'h0000, 8'h00},
    '{4'h5, 3'h4, 8'hED, 8'h05, 8'h00, 8'h10, 5'h00, 16'h0015, 16'h0000, 8'h00},
    '{4'h2, 3'h2, 8'h3D, 8'h40, 8'h00, 8'h00, 5'h04, 16'h10F2, 16'h0040, 8'h00},
    '{4'h8, 3'h6, 8'h15, 8'h7F, 8'h00, 8'h00, 5'h06, 16'h10F2, 16'h007F, 8'h21},
    '{4'h8, 3'h6, 8'h14, 8'h80, 8'h00, 8'h00, 5'h04, 16'h10F2, 16'h0080, 8'h00},
    '{4'h9, 3'h6, 8'h02, 8'hC0, 8'hFE, 8'h00, 5'h0D, 16'h10F1, 16'h00C0, 8'h00},
    '{4'h0, 3'h7, 8'h4C, 8'h00, 8'h00, 8'h00, 5'h00, 16'h10F1, 16'h0000, 8'h00},
    '{4'h9, 3'h6, 8'h03, 8'hC0, 8'hFE, 8'h00, 5'h05, 16'h10F3, 16'h00C0, 8'h00},
    '{4'h8, 3'h6, 8'h1A, 8'h10, 8'h00, 8'h00, 5'h06, 16'h10F2, 16'h0010, 8'h6A}};
  logic sys_clk = 1'h0, sys_rst = 1'h1, instr_valid = 1'h0, branch_cond = 1'h0, bit_sense = 1'h0;
  logic [3:0] addr_mode = 4'h0;
  logic [2:0] instr_class = 3'h0;
  logic [7:0] opcode = 8'h00, byte1 = 8'h00, byte2 = 8'h00, index_x = 8'h00, wd_seen;
  logic [15:0] pc_in = 16'h10F0, ea_seen;
  logic [15:0] rd_cnt = 16'h0000, wr_cnt = 16'h0000, rd_base, wr_base;
  logic taken_exp;
  wire [7:0] read_data, alu_result, addr_high, addr_low, write_data;
  wire [15:0] pc_out;
  wire mem_read, mem_write, pc_load, carry_load, carry_value, branch_taken, done;
  int err_total = 0, n_tests = 0;
  ceau_unit dut (.*);
  ceau_mem_model mem_model (.*);
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (mem_read === 1'h1) begin
      rd_cnt  <= rd_cnt + 16'h0001;
      ea_seen <= {addr_high, addr_low};
    end
    if (mem_write === 1'h1) begin
      wr_cnt  <= wr_cnt + 16'h0001;
      wd_seen <= write_data;
    end
  end
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apply(ceau_row_t r);
    rd_base = rd_cnt;
    wr_base = wr_cnt;
    {addr_mode, instr_class, opcode, byte1, byte2, index_x} = {r.m, r.c, r.op, r.b1, r.b2, r.x};
    {branch_cond, bit_sense} = r.f[4:3];
    instr_valid = 1'h1;
  endtask
  // Waits are bounded; a missing done ends the run as a mismatch.
  task automatic wait_done;
    @(posedge sys_clk) #2;
    instr_valid = 1'h0;
    for (int k = 0; k < 8 && done !== 1'h1; k++) @(posedge sys_clk) #2;
    if (done !== 1'h1) begin
      err_total++;
      complete_run();
    end
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    #2;
    check("reset address", {addr_high, addr_low}, 16'h0000);
    check("reset strobes", {mem_read, mem_write, done, pc_load, carry_load}, 16'h0000);
    check("reset pc_out", pc_out, 16'h0000);
    check("reset write_data", write_data, 16'h0000);
    check("reset flags", {carry_value, branch_taken}, 16'h0000);
    $display("reset finished");
    sys_rst = 1'h0;
    foreach (ROWS[i]) begin
      apply(ROWS[i]);
      wait_done();
      taken_exp = (ROWS[i].m == 4'h7 && ROWS[i].f[4]) ||
                  (ROWS[i].m == 4'h9 && ROWS[i].f[0] == ROWS[i].f[3]);
      check("pc_out", pc_out, ROWS[i].pc);
      check("pc_load", pc_load, 16'h0001);
      check("taken", branch_taken, taken_exp);
      check("read", rd_cnt - rd_base, ROWS[i].f[2]);
      if (ROWS[i].f[2]) check("address", ea_seen, ROWS[i].ea);
      check("write", wr_cnt - wr_base, ROWS[i].f[1]);
      if (ROWS[i].f[1]) check("write_data", wd_seen, ROWS[i].wd);
      if (ROWS[i].m == 4'h9) check("carry", {carry_load, carry_value}, {1'h1, ROWS[i].f[0]});
      $display("row %0d finished", i);
    end
    apply(ROWS[0]);
    @(posedge sys_clk) #2;
    check("back to back done", done, 1'h1);
    apply(ROWS[6]);
    wait_done();
    check("back to back pc", pc_out, 16'h1072);
    $display("back to back finished");
    apply(ROWS[1]);
    @(posedge sys_clk) #2;
    instr_valid = 1'h0;
    sys_rst = 1'h1;
    #2;
    check("aborted outputs", {mem_read, mem_write, done, pc_load, write_data}, 16'h0000);
    @(posedge sys_clk) #2;
    sys_rst = 1'h0;
    repeat (4) @(posedge sys_clk);
    #2;
    check("no write after abort", wr_cnt - wr_base, 16'h0000);
    check("idle after abort", {done, mem_read, mem_write}, 16'h0000);
    apply(ROWS[2]);
    wait_done();
    check("pc after abort", pc_out, ROWS[2].pc);
    check("read after abort", rd_cnt - rd_base, 16'h0001);
    $display("abort finished");
    complete_run();
  end
endmodule

`default_nettype wire
